// ===== core/pmcc_core.sv
// power-mode, wake-up, band-gap, ring oscillator and timed-access control
//
// Behaviour
// - Setting bit 0 of power control register at 87h enters Idle.
// - Idle keeps clocks, serial port and timers running; processor halted.
// - Idle ends on any enabled interrupt or reset.
// - Setting bit 1 enters Stop; all clocks and crystal gated off.
// - Stop ends only on external interrupt, power-fail with band-gap kept on, or reset.
// - Band-gap off in Stop unless keep-on bit 0 at 91h set; resets 0.
// - Band-gap kept on: power-fail interrupt and reset active, wake Stop.
// - Band-gap keep-on bit has no effect in run or Idle.
// - Ring select set: wake from Stop on ring oscillator, else crystal.
// - Ring start applies when Stop is left by an interrupt.
// - Running on ring: switch to crystal after 65536 crystal clocks.
// - Stop re-entered before hand-over turns all clocks off again.
// - Ring active flag, bit 2 at 91h, reads 1 while ring clocks device.
// - Writing AAh then 55h to key register C7h opens three-cycle window.
// - Protected-bit writes ignored unless made inside the three-cycle window the key sequence opens.
// - Protected: band-gap keep-on, power-on flag, watchdog enable, restart, irq flag.
`timescale 1ns/1ns
module pmcc_core #(
	parameter int HANDOVER_CLOCKS = pmcc_pkg::RING_HANDOVER_CLOCKS
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	// wake sources and crystal ready
	input  wire logic       irq_enabled_any,
	input  wire logic       irq_external,
	input  wire logic       power_fail_warning_irq,
	input  wire logic       power_fail_reset,
	input  wire logic       crystal_ready,
	// watchdog side effects
	input  wire logic       watchdog_irq_set,
	input  wire logic       por_flag_set,
	output logic            watchdog_enable_bit,
	output logic            watchdog_restart_bit,
	output logic            watchdog_irq_flag,
	output logic            por_flag,
	// clock and power controls
	output logic            cpu_clock_en,
	output logic            periph_clock_en,
	output logic            crystal_en,
	output logic            ring_en,
	output logic            bandgap_en,
	output logic            ring_active_flag,
	output logic            idle_mode,
	output logic            stop_mode,
	output logic            key_window_open
);
	localparam int CW = $clog2(HANDOVER_CLOCKS + 1);

	pmcc_pkg::pmcc_mode_e mode_reg, mode_next;
	pmcc_pkg::pmcc_key_e  key_reg, key_next;
	logic [1:0]  win_reg, win_next;
	logic [7:0]  power_control_reg;
	logic [7:0]  extended_flag_reg;
	logic [7:0]  watchdog_control_reg;
	logic        ring_reg, ring_next;
	logic [CW-1:0] hand_reg, hand_next;
	logic        bandgap_keep_on;
	logic        ring_wake_select;
	logic [7:0]  rdata_reg;

	// address decode
	wire wr_power_control = sfr_wr && (sfr_addr == pmcc_pkg::ADDR_POWER_CONTROL);
	wire wr_extended_flag_and_wake_control = sfr_wr && (sfr_addr == pmcc_pkg::ADDR_EXT_FLAG);
	wire wr_key  = sfr_wr && (sfr_addr == pmcc_pkg::ADDR_ACCESS_KEY);
	wire wr_wdog = sfr_wr && (sfr_addr == pmcc_pkg::ADDR_WDOG_CONTROL);
	// a protected write consumes the window whether it hits or not
	wire unlocked  = (key_reg == pmcc_pkg::PMCC_KEY_OPEN);
	wire prot_wr   = unlocked && (wr_extended_flag_and_wake_control || wr_wdog);
	wire enter_idle = wr_power_control && sfr_wdata[pmcc_pkg::BIT_IDLE];
	wire enter_stop = wr_power_control && sfr_wdata[pmcc_pkg::BIT_STOP];
	// only external pins, or power-fail with band-gap on, reach Stop
	wire pf_in_stop = bandgap_keep_on && (power_fail_warning_irq || power_fail_reset);
	wire stop_wake  = irq_external || pf_in_stop;
	// a power-fail reset wakes Stop but is no interrupt, so it never starts the ring
	wire stop_irq_wake = irq_external || (bandgap_keep_on && power_fail_warning_irq);
	wire handover_done = (hand_reg == CW'(HANDOVER_CLOCKS));

	assign bandgap_keep_on  = extended_flag_reg[pmcc_pkg::BIT_BANDGAP_KEEP];
	assign ring_wake_select = extended_flag_reg[pmcc_pkg::BIT_RING_SELECT];

	// key sequencer: AAh, then 55h, then a short window
	always_comb begin
		key_next = key_reg;
		win_next = win_reg;
		case (key_reg)
			pmcc_pkg::PMCC_KEY_IDLE: begin
				if (wr_key && sfr_wdata == pmcc_pkg::KEY_FIRST) key_next = pmcc_pkg::PMCC_KEY_FIRST;
			end
			pmcc_pkg::PMCC_KEY_FIRST: begin
				if (wr_key && sfr_wdata == pmcc_pkg::KEY_SECOND) begin
					key_next = pmcc_pkg::PMCC_KEY_OPEN;
					win_next = pmcc_pkg::KEY_WINDOW_CYCLES;
				end else if (wr_key && sfr_wdata == pmcc_pkg::KEY_FIRST) begin
					key_next = pmcc_pkg::PMCC_KEY_FIRST;
				end else if (sfr_wr) begin
					key_next = pmcc_pkg::PMCC_KEY_IDLE;
				end
			end
			pmcc_pkg::PMCC_KEY_OPEN: begin
				win_next = win_reg - 2'h1;
				if (prot_wr || wr_key || win_reg == 2'h1) key_next = pmcc_pkg::PMCC_KEY_IDLE;
			end
			default: key_next = pmcc_pkg::PMCC_KEY_IDLE;
		endcase
	end

	// power mode sequencing
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			pmcc_pkg::PMCC_RUN: begin
				if (enter_stop) mode_next = pmcc_pkg::PMCC_STOP;
				else if (enter_idle) mode_next = pmcc_pkg::PMCC_IDLE;
			end
			pmcc_pkg::PMCC_IDLE: begin
				if (irq_enabled_any) mode_next = pmcc_pkg::PMCC_RUN;
			end
			pmcc_pkg::PMCC_STOP: begin
				if (stop_wake) mode_next = pmcc_pkg::PMCC_RUN;
			end
			default: mode_next = pmcc_pkg::PMCC_RUN;
		endcase
	end

	// ring-oscillator run and hand-over count on crystal clocks
	always_comb begin
		ring_next = ring_reg;
		hand_next = hand_reg;
		if (mode_reg == pmcc_pkg::PMCC_STOP) begin
			hand_next = '0;
			ring_next = 1'b0;
			if (stop_irq_wake && ring_wake_select) ring_next = 1'b1;
		end else if (ring_reg) begin
			if (crystal_ready && !handover_done) hand_next = hand_reg + CW'(1);
			if (handover_done) ring_next = 1'b0;
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_reg <= pmcc_pkg::PMCC_RUN;
			key_reg  <= pmcc_pkg::PMCC_KEY_IDLE;
			win_reg  <= '0;
			ring_reg <= 1'b0;
			hand_reg <= '0;
		end else begin
			mode_reg <= mode_next;
			key_reg  <= key_next;
			win_reg  <= win_next;
			ring_reg <= ring_next;
			hand_reg <= hand_next;
		end
	end

	// power control register; mode bits clear when the mode ends
	always_ff @(posedge clk) begin
		if (rst) begin
			power_control_reg <= pmcc_pkg::POWER_CONTROL_RST;
		end else if (wr_power_control) begin
			power_control_reg <= sfr_wdata;
		end else if (mode_next == pmcc_pkg::PMCC_RUN) begin
			power_control_reg[pmcc_pkg::BIT_IDLE] <= 1'b0;
			power_control_reg[pmcc_pkg::BIT_STOP] <= 1'b0;
		end
	end

	// extended flag: keep-on is key protected, ring select is open
	always_ff @(posedge clk) begin
		if (rst) begin
			extended_flag_reg <= pmcc_pkg::EXT_FLAG_RST;
		end else if (wr_extended_flag_and_wake_control) begin
			extended_flag_reg[pmcc_pkg::BIT_RING_SELECT] <= sfr_wdata[pmcc_pkg::BIT_RING_SELECT];
			if (unlocked)
				extended_flag_reg[pmcc_pkg::BIT_BANDGAP_KEEP] <= sfr_wdata[pmcc_pkg::BIT_BANDGAP_KEEP];
		end
	end

	// watchdog control protected bits; hardware set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			watchdog_control_reg <= pmcc_pkg::WDOG_CONTROL_RST;
		end else begin
			watchdog_control_reg[pmcc_pkg::BIT_WD_RESTART] <= 1'b0; // restart is a pulse
			if (wr_wdog && unlocked) begin
				watchdog_control_reg[pmcc_pkg::BIT_WD_RESTART] <= sfr_wdata[pmcc_pkg::BIT_WD_RESTART];
				watchdog_control_reg[pmcc_pkg::BIT_WD_ENABLE]  <= sfr_wdata[pmcc_pkg::BIT_WD_ENABLE];
				watchdog_control_reg[pmcc_pkg::BIT_WD_IRQ]     <= sfr_wdata[pmcc_pkg::BIT_WD_IRQ];
				watchdog_control_reg[pmcc_pkg::BIT_POR_FLAG]   <= sfr_wdata[pmcc_pkg::BIT_POR_FLAG];
			end
			if (watchdog_irq_set) watchdog_control_reg[pmcc_pkg::BIT_WD_IRQ] <= 1'b1;
			if (por_flag_set) watchdog_control_reg[pmcc_pkg::BIT_POR_FLAG] <= 1'b1;
		end
	end

	// read data mux
	wire [7:0] extended_flag_and_wake_control_view = {5'h00, ring_reg, extended_flag_reg[pmcc_pkg::BIT_RING_SELECT],
		bandgap_keep_on};
	wire [7:0] rd_mux = (sfr_addr == pmcc_pkg::ADDR_POWER_CONTROL) ? power_control_reg :
		(sfr_addr == pmcc_pkg::ADDR_EXT_FLAG) ? extended_flag_and_wake_control_view :
		(sfr_addr == pmcc_pkg::ADDR_WDOG_CONTROL) ? watchdog_control_reg : 8'h00;

	// registered read; key register reads as zero
	always_ff @(posedge clk) begin
		if (rst) rdata_reg <= 8'h00;
		else if (sfr_rd) rdata_reg <= rd_mux;
	end

	// clock and power outputs
	assign sfr_rdata            = rdata_reg;
	assign idle_mode            = (mode_reg == pmcc_pkg::PMCC_IDLE);
	assign stop_mode            = (mode_reg == pmcc_pkg::PMCC_STOP);
	assign cpu_clock_en         = (mode_reg == pmcc_pkg::PMCC_RUN);
	assign periph_clock_en      = !stop_mode;
	assign crystal_en           = !stop_mode;
	assign ring_en              = ring_reg;
	assign ring_active_flag     = ring_reg;
	// keep-on only matters in Stop; reference always on otherwise
	assign bandgap_en           = !stop_mode || bandgap_keep_on;
	assign watchdog_enable_bit  = watchdog_control_reg[pmcc_pkg::BIT_WD_ENABLE];
	assign watchdog_restart_bit = watchdog_control_reg[pmcc_pkg::BIT_WD_RESTART];
	assign watchdog_irq_flag    = watchdog_control_reg[pmcc_pkg::BIT_WD_IRQ];
	assign por_flag             = watchdog_control_reg[pmcc_pkg::BIT_POR_FLAG];
	assign key_window_open      = unlocked;
endmodule

// ===== inc/pmcc_pkg.sv
// constants for the power-mode and clock-source control block
package pmcc_pkg;
	// special-function addresses
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_EXT_FLAG      = 8'h91;
	localparam logic [7:0] ADDR_ACCESS_KEY    = 8'hC7;
	localparam logic [7:0] ADDR_WDOG_CONTROL  = 8'hD8;
	// power control fields
	localparam int BIT_IDLE = 0;
	localparam int BIT_STOP = 1;
	// extended flag fields
	localparam int BIT_BANDGAP_KEEP = 0;
	localparam int BIT_RING_SELECT  = 1;
	localparam int BIT_RING_ACTIVE  = 2;
	// watchdog control fields
	localparam int BIT_WD_RESTART = 0;
	localparam int BIT_WD_ENABLE  = 1;
	localparam int BIT_WD_IRQ     = 3;
	localparam int BIT_POR_FLAG   = 6;
	// reset values
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
	localparam logic [7:0] EXT_FLAG_RST      = 8'h00;
	localparam logic [7:0] WDOG_CONTROL_RST  = 8'h00;
	// key bytes and window length
	localparam logic [7:0] KEY_FIRST  = 8'hAA;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	localparam logic [1:0] KEY_WINDOW_CYCLES = 2'h3;
	// crystal clocks before hand-over from ring to crystal
	localparam int RING_HANDOVER_CLOCKS = 65536;
	// power modes
	typedef enum logic [1:0] {PMCC_RUN, PMCC_IDLE, PMCC_STOP} pmcc_mode_e;
	// key sequencer states
	typedef enum logic [1:0] {PMCC_KEY_IDLE, PMCC_KEY_FIRST, PMCC_KEY_OPEN} pmcc_key_e;
endpackage

// ===== tb/pmcc_core_sva.sv
// port assertions for the power-mode and clock control core
`timescale 1ns/1ns
module pmcc_core_sva #(
	parameter int HANDOVER_CLOCKS = 8
) (
	// clock, reset and register port
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// wake sources and crystal ready
	input wire logic       irq_enabled_any,
	input wire logic       irq_external,
	input wire logic       power_fail_warning_irq,
	input wire logic       power_fail_reset,
	input wire logic       crystal_ready,
	// controls
	input wire logic       cpu_clock_en,
	input wire logic       periph_clock_en,
	input wire logic       crystal_en,
	input wire logic       bandgap_en,
	input wire logic       ring_active_flag,
	input wire logic       idle_mode,
	input wire logic       stop_mode,
	input wire logic       key_window_open
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [31:0] ring_cnt_reg;
	wire         pc_wr = sfr_wr && sfr_addr == pmcc_pkg::ADDR_POWER_CONTROL;
	// crystal clocks seen on ring; one spare for the registered drop
	always_ff @(posedge clk) begin
		if (rst || !ring_active_flag)
			ring_cnt_reg <= 32'h0;
		else if (crystal_ready)
			ring_cnt_reg <= ring_cnt_reg + 32'h1;
	end
	a_stop_gates_clocks: assert property (stop_mode |-> !cpu_clock_en && !periph_clock_en && !crystal_en) else $error("clock on in stop");
	a_idle_keeps_clocks: assert property (idle_mode |-> !cpu_clock_en && periph_clock_en && crystal_en) else $error("idle clocks wrong");
	a_idle_entry: assert property (pc_wr && sfr_wdata[0] && !sfr_wdata[1] && !stop_mode && !irq_enabled_any |=> idle_mode) else $error("no idle");
	a_stop_entry: assert property (pc_wr && sfr_wdata[1] && !stop_mode |=> stop_mode) else $error("no stop");
	a_stop_wake_only: assert property (stop_mode && !irq_external && !(bandgap_en && (power_fail_warning_irq || power_fail_reset)) |=> stop_mode) else $error("bad stop wake");
	a_idle_wake_irq: assert property (idle_mode && irq_enabled_any |=> !idle_mode) else $error("idle not left");
	a_bandgap_full_power: assert property (!stop_mode |-> bandgap_en) else $error("bandgap off outside stop");
	a_ring_handover: assert property (ring_cnt_reg <= HANDOVER_CLOCKS + 1) else $error("ring kept too long");
	a_key_window_len: assert property (key_window_open [*3] |=> !key_window_open) else $error("window too long");
	a_key_opens_after: assert property ($rose(key_window_open) |-> $past(sfr_wr && sfr_addr == pmcc_pkg::ADDR_ACCESS_KEY && sfr_wdata == pmcc_pkg::KEY_SECOND)) else $error("window without key");
	a_key_reads_zero: assert property (sfr_rd && sfr_addr == pmcc_pkg::ADDR_ACCESS_KEY |=> sfr_rdata == 8'h00) else $error("key reg readable");
	c_ring_wake: cover property (stop_mode ##1 !stop_mode && ring_active_flag);
	c_idle_wake: cover property (idle_mode ##1 !idle_mode);
	c_key_open: cover property (key_window_open);
endmodule
bind pmcc_core pmcc_core_sva #(.HANDOVER_CLOCKS(HANDOVER_CLOCKS)) i_pmcc_core_sva (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq_enabled_any(irq_enabled_any),
	.irq_external(irq_external), .power_fail_warning_irq(power_fail_warning_irq), .power_fail_reset(power_fail_reset),
	.crystal_ready(crystal_ready), .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en), .crystal_en(crystal_en),
	.bandgap_en(bandgap_en), .ring_active_flag(ring_active_flag), .idle_mode(idle_mode), .stop_mode(stop_mode),
	.key_window_open(key_window_open));

// ===== tb/pmcc_core_tb.sv
// self-checking bench for the power-mode and clock control core
`timescale 1ns/1ns
module pmcc_core_tb;
	localparam int HC = 8;
	logic        clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, irq_enabled_any = 1'b0, irq_external = 1'b0;
	logic        power_fail_warning_irq = 1'b0, crystal_ready = 1'b0, watchdog_irq_set = 1'b0, por_flag_set = 1'b0;
	logic        power_fail_reset = 1'b0, wd_rst, ring_en;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, k;
	logic        wd_en, wd_irq, por_flag, cpu_clock_en, periph_clock_en, crystal_en, bandgap_en;
	logic        ring_active_flag, idle_mode, stop_mode, key_window_open;
	logic [31:0] seed = 32'h3A;
	int          failures = 0, num_checks = 0;
	pmcc_core #(.HANDOVER_CLOCKS(HC)) i_pmcc_core (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq_enabled_any(irq_enabled_any),
		.irq_external(irq_external), .power_fail_warning_irq(power_fail_warning_irq), .power_fail_reset(power_fail_reset),
		.crystal_ready(crystal_ready), .watchdog_irq_set(watchdog_irq_set), .por_flag_set(por_flag_set),
		.watchdog_enable_bit(wd_en), .watchdog_restart_bit(wd_rst), .watchdog_irq_flag(wd_irq), .por_flag(por_flag),
		.cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en), .crystal_en(crystal_en), .ring_en(ring_en),
		.bandgap_en(bandgap_en), .ring_active_flag(ring_active_flag), .idle_mode(idle_mode), .stop_mode(stop_mode),
		.key_window_open(key_window_open));
	// free-running bus clock
	always #5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// expected flag register read from ring state, ring select and keep-on bit
	function automatic logic [7:0] flagv(input logic act, input logic sel, input logic keep);
		return {5'h00, act, sel, keep};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one write taken at the next edge; strobe left high for back-to-back use
	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc(1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr1(a, d);
		sfr_wr = 1'b0;
		cyc(1);
	endtask
	// key bytes then the protected write, all on consecutive edges
	task automatic keyed(input logic [7:0] a, input logic [7:0] d);
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_FIRST);
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_SECOND);
		wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_rd = 1'b1;
		cyc(1);
		sfr_rd = 1'b0;
		chk(sfr_rdata, exp);
		cyc(1);
	endtask
	task automatic go_stop;
		wr(pmcc_pkg::ADDR_POWER_CONTROL, 8'h02);
		chk({stop_mode, cpu_clock_en, periph_clock_en, crystal_en}, 8'h08);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard well past the expected run length
	initial begin
		#40000;
		failures++;
		give_verdict();
	end
	initial begin
		cyc(8);
		rst = 1'b0;
		rd(pmcc_pkg::ADDR_POWER_CONTROL, 8'h00);
		rd(pmcc_pkg::ADDR_EXT_FLAG, 8'h00);
		rd(pmcc_pkg::ADDR_ACCESS_KEY, 8'h00);
		rd(8'h3C, 8'h00);
		$display("test reset done");
		wr(pmcc_pkg::ADDR_POWER_CONTROL, 8'h01);
		chk({idle_mode, cpu_clock_en, periph_clock_en, crystal_en, bandgap_en}, 8'h17);
		irq_enabled_any = 1'b1;
		cyc(2);
		irq_enabled_any = 1'b0;
		chk(idle_mode, 1'b0);
		$display("test idle done");
		seed = xs(seed);
		wr(pmcc_pkg::ADDR_EXT_FLAG, 8'h01);
		wr(pmcc_pkg::ADDR_WDOG_CONTROL, seed[7:0] & 8'h4B);
		rd(pmcc_pkg::ADDR_EXT_FLAG, 8'h00);
		rd(pmcc_pkg::ADDR_WDOG_CONTROL, 8'h00);
		k = seed[15:8] ^ ((seed[15:8] == 8'h55 || seed[15:8] == 8'hAA) ? 8'h01 : 8'h00);
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_FIRST);
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, k);
		wr(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_SECOND);
		chk(key_window_open, 1'b0);
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_FIRST);
		wr(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_SECOND);
		chk(key_window_open, 1'b1);
		cyc(3);
		chk(key_window_open, 1'b0);
		wr(pmcc_pkg::ADDR_WDOG_CONTROL, 8'h02);
		chk(wd_en, 1'b0);
		keyed(pmcc_pkg::ADDR_WDOG_CONTROL, 8'h02);
		chk(wd_en, 1'b1);
		watchdog_irq_set = 1'b1;
		por_flag_set = 1'b1;
		cyc(1);
		watchdog_irq_set = 1'b0;
		por_flag_set = 1'b0;
		cyc(1);
		chk({wd_irq, por_flag}, 8'h03);
		// keyed restart with enable set: the restart bit pulses for one cycle
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_FIRST);
		wr1(pmcc_pkg::ADDR_ACCESS_KEY, pmcc_pkg::KEY_SECOND);
		wr1(pmcc_pkg::ADDR_WDOG_CONTROL, 8'h03);
		chk(wd_rst, 1'b1);
		sfr_wr = 1'b0;
		cyc(1);
		chk({wd_rst, wd_en}, 8'h01);
		$display("test key done");
		go_stop();
		chk(bandgap_en, 1'b0);
		irq_enabled_any = 1'b1;
		power_fail_warning_irq = 1'b1;
		power_fail_reset = 1'b1;
		cyc(4);
		chk(stop_mode, 1'b1);
		irq_enabled_any = 1'b0;
		power_fail_warning_irq = 1'b0;
		power_fail_reset = 1'b0;
		irq_external = 1'b1;
		cyc(1);
		irq_external = 1'b0;
		cyc(1);
		chk({stop_mode, ring_active_flag}, 8'h00);
		keyed(pmcc_pkg::ADDR_EXT_FLAG, 8'h03);
		rd(pmcc_pkg::ADDR_EXT_FLAG, flagv(1'b0, 1'b1, 1'b1));
		go_stop();
		chk(bandgap_en, 1'b1);
		power_fail_warning_irq = 1'b1;
		cyc(1);
		power_fail_warning_irq = 1'b0;
		cyc(1);
		chk({stop_mode, ring_active_flag, ring_en}, 8'h03);
		rd(pmcc_pkg::ADDR_EXT_FLAG, flagv(1'b1, 1'b1, 1'b1));
		go_stop();
		irq_external = 1'b1;
		cyc(1);
		irq_external = 1'b0;
		crystal_ready = 1'b1;
		cyc(HC - 1);
		chk(ring_active_flag, 1'b1);
		cyc(3);
		crystal_ready = 1'b0;
		chk(ring_active_flag, 1'b0);
		// a power-fail reset wakes Stop with the band-gap on, but starts no ring
		go_stop();
		power_fail_reset = 1'b1;
		cyc(1);
		power_fail_reset = 1'b0;
		cyc(1);
		chk({stop_mode, ring_active_flag, ring_en}, 8'h00);
		$display("test stop done");
		give_verdict();
	end
endmodule
